// ### pkg/asr_regs.svh
// register offsets, fields, reset values and timing counts of the receiver
// assumes 32-bit axi4-lite, one aligned word per register
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
`define ASR_OFF_CTRL      12'h000
`define ASR_OFF_STATUS    12'h004
`define ASR_OFF_DATA      12'h008
`define ASR_OFF_RATE      12'h00c
`define ASR_OFF_IRQ_STAT  12'h010
`define ASR_OFF_IRQ_MASK  12'h014
`define ASR_OFF_TIMER1    12'h018
`define ASR_OFF_TIMER2    12'h01c
// ctrl fields
`define ASR_CTRL_RXEN     0
`define ASR_CTRL_WAKE     1
`define ASR_CTRL_STOP2    2
`define ASR_CTRL_PAREN    3
`define ASR_CTRL_PARODD   4
`define ASR_CTRL_SRC      5
`define ASR_CTRL_T2SEL    6
// status fields
`define ASR_ST_FULL       0
`define ASR_ST_OVERRUN_FRAMING_ERR_FLAG       1
`define ASR_ST_PAR        2
`define ASR_ST_BUSY       3
// irq fields
`define ASR_IRQ_FULL      0
`define ASR_IRQ_OVERRUN_FRAMING_ERR_FLAG      1
`define ASR_IRQ_PAR       2
// reset values
`define ASR_RATE_RESET    16'h000c
`define ASR_CTRL_RESET    7'h00
// sampling ratio and timer2 e/8, e/128 dividers
`define ASR_OVERSAMPLE    16
`define ASR_E8_DIV        8
`define ASR_E128_DIV      128
`endif

// ### pkg/asr_pkg.sv
// types shared by the serial receiver modules
// assumes asr_regs.svh supplies the numeric constants
package asr_pkg;
    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_START,
        ASR_DATA,
        ASR_PARITY,
        ASR_STOP1,
        ASR_STOP2
    } asr_state_e;

    typedef struct packed {
        logic [15:0] div;
        logic        tick;
    } asr_rate_s;

    typedef struct packed {
        asr_state_e  state;
        logic [3:0]  phase;
        logic [2:0]  bitIdx;
        logic [7:0]  shift;
        logic        parErr;
        logic        frmErr;
        logic        lineOld;
        logic        done;
        logic [7:0]  dataOut;
        logic        doneParErr;
        logic        doneFrmErr;
    } asr_rx_s;

    function automatic logic asr_parity(input logic [7:0] d, input logic odd);
        asr_parity = (^d) ^ odd;
    endfunction
endpackage

// ### pkg/asr_rx_if.sv
// frame completion link between the bit engine and the register block
// assumes both ends share clk
`timescale 1ns/100ps
interface asr_rx_if;
    logic       done;
    logic [7:0] data;
    logic       parErr;
    logic       frmErr;
    logic       busy;
    modport engine (output done, data, parErr, frmErr, busy);
    modport regs   (input done, data, parErr, frmErr, busy);
endinterface

// ### rtl/asr_rate_gen.sv
// bit-rate generator: timer1 free counter and timer2 counter, x16 tick
// assumes software keeps the selected counter untouched while receiving
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_rate_gen
    import asr_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // configuration
    input  wire logic             useTimer2,
    input  wire logic             t2Slow,
    input  wire logic [DIV_W-1:0] rateDiv,
    // counter writes
    input  wire logic             t1Write,
    input  wire logic             t2Write,
    input  wire logic [DIV_W-1:0] wrData,
    // outputs
    output logic [DIV_W-1:0]      t1Count,
    output logic [DIV_W-1:0]      t2Count,
    output logic                  sampleTick
);
    if (DIV_W < 8) begin
        $error("asr_rate_gen: DIV_W too small");
    end

    typedef struct packed {
        logic [DIV_W-1:0] t1;
        logic [DIV_W-1:0] t2;
        logic [DIV_W-1:0] acc;
        logic             tick;
    } asr_gen_s;

    asr_gen_s s_q, s_d;
    logic     t1E8, t1E128, t2Step, srcStep;

    always_comb begin
        s_d    = s_q;
        // e/8 and e/128 come off the free counter, so its writes delay t2 [R13]
        t1E8   = (s_q.t1[2:0] == 3'h7);
        t1E128 = (s_q.t1[6:0] == 7'h7f);
        t2Step = t2Slow ? t1E128 : t1E8;
        srcStep = useTimer2 ? t2Step : 1'b1;
        // runs on the internal clock only, never stretched by bus waits [R15]
        s_d.t1 = s_q.t1 + 1'b1;
        if (t1Write) begin
            s_d.t1 = wrData; // a write restarts timing, delaying bits [R14]
        end
        if (t2Step) begin
            s_d.t2 = s_q.t2 + 1'b1;
        end
        if (t2Write) begin
            s_d.t2 = wrData; // [R14]
        end
        s_d.tick = 1'b0;
        if ((useTimer2 && t2Write) || (!useTimer2 && t1Write)) begin
            s_d.acc = '0; // [R14]
        end else if (srcStep) begin
            // one tick per rateDiv+1 source steps gives the x16 rate [R1] [R13]
            if (s_q.acc >= rateDiv) begin
                s_d.acc  = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.acc = s_q.acc + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign t1Count    = s_q.t1;
    assign t2Count    = s_q.t2;
    assign sampleTick = s_q.tick;
endmodule

// ### rtl/asr_bit_engine.sv
// bit engine: start detect, 16x sampling, parity and stop checks
// assumes sampleTick is a one-cycle pulse at sixteen times the bit rate
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_bit_engine
    import asr_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // control
    input  wire logic sampleTick,
    input  wire logic active,
    input  wire logic stop2,
    input  wire logic parEn,
    input  wire logic parOdd,
    // line
    input  wire logic rxLine,
    // frame out
    asr_rx_if.engine  fr
);
    asr_rx_s s_q, s_d;
    logic    fallEdge, midTick, riseTick;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        // phase 0..7 is the low half of the sampling clock, 8..15 the high
        // half: the falling edge detects, the rising edge samples [R2]
        riseTick = sampleTick && (s_q.phase == 4'h7);
        midTick  = sampleTick && (s_q.phase == 4'hf);
        fallEdge = s_q.lineOld && !rxLine;
        if (sampleTick) begin
            s_d.lineOld = rxLine;
            s_d.phase   = s_q.phase + 4'h1;
        end
        case (s_q.state)
            ASR_IDLE: begin
                if (active && sampleTick && !rxLine) begin
                    // level detect: a held-low line after a bad stop still
                    // starts a frame, so breaks show as framing errors [R3]
                    if (fallEdge) begin
                        s_d.phase = 4'h1; // retime on the edge only [R4]
                    end
                    s_d.state  = ASR_START;
                    s_d.parErr = 1'b0;
                    s_d.frmErr = 1'b0;
                    s_d.bitIdx = 3'h0;
                end
            end
            ASR_START: begin
                if (riseTick) begin
                    // a start that is high again was a glitch [R2]
                    s_d.state = rxLine ? ASR_IDLE : ASR_START;
                end else if (midTick) begin
                    s_d.state = ASR_DATA;
                end
            end
            ASR_DATA: begin
                if (riseTick) begin
                    s_d.shift = {rxLine, s_q.shift[7:1]}; // [R2]
                end
                if (midTick) begin
                    s_d.bitIdx = s_q.bitIdx + 3'h1;
                    if (s_q.bitIdx == 3'h7) begin
                        s_d.state = parEn ? ASR_PARITY : ASR_STOP1;
                    end
                end
            end
            ASR_PARITY: begin
                if (riseTick) begin
                    s_d.parErr = asr_parity(s_q.shift, parOdd) != rxLine;
                end
                if (midTick) begin
                    s_d.state = ASR_STOP1;
                end
            end
            ASR_STOP1: begin
                if (riseTick) begin
                    s_d.frmErr = !rxLine;
                    if (!stop2) begin
                        s_d.state = ASR_IDLE;
                        s_d.done  = 1'b1;
                    end
                end
                if (midTick && stop2) begin
                    s_d.state = ASR_STOP2;
                end
            end
            ASR_STOP2: begin
                if (riseTick) begin
                    // either stop bit low is a framing error [R11]
                    s_d.frmErr = s_q.frmErr || !rxLine;
                    s_d.state  = ASR_IDLE;
                    s_d.done   = 1'b1;
                end
            end
            default: s_d.state = ASR_IDLE;
        endcase
        if (s_d.done) begin
            s_d.dataOut    = s_d.shift;
            s_d.doneParErr = s_d.parErr;
            s_d.doneFrmErr = s_d.frmErr;
        end
        if (!active) begin
            s_d.state = ASR_IDLE;
            s_d.done  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q         <= '0;
            s_q.state   <= ASR_IDLE;
            s_q.lineOld <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign fr.done   = s_q.done;
    assign fr.data   = s_q.dataOut;
    assign fr.parErr = s_q.doneParErr;
    assign fr.frmErr = s_q.doneFrmErr;
    assign fr.busy   = (s_q.state != ASR_IDLE);
endmodule

// ### rtl/async_serial_receiver.sv
// asynchronous serial receiver with axi4-lite registers and one interrupt
// assumes rxLine is synchronous to clk and idles high
//
// Behaviour
// R1: the sampling clock runs at sixteen times the configured bit rate.
// R2: start is found on the falling half and bits are sampled on the rising half of the sampling clock.
// R3: a low line level starts a frame, so frames follow a framing error and breaks are seen.
// R4: timing is cleared on a start falling edge and kept otherwise.
// R5: software sets receive enable before wake-up; wake-up in the same write as enable is not set.
// R6: writing zero to wake-up clears it and receiving resumes the next cycle.
// R7: normal, overrun, parity and framing frames set the flags as tabled.
// R8: overrun with any other error reports overrun only.
// R9: parity plus framing without overrun sets both error flags and not data full.
// R10: a frame with parity and framing errors still loads the data register.
// R11: with two stop bits both are checked for framing.
// R12: data moves to the data register only while data full is clear.
// R13: the bit rate comes from timer1 or timer2, timer2 fed by e/8 or e/128 off timer1.
// R14: writing the selected counter delays bit timing.
// R15: bit timing runs from the internal clock and no bus wait alters it.
// R16: data full stays zero while wake-up is set with receive enabled.
// R17: data full and overrun/framing clear on a status read then a data read.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "asr_regs.svh"
module async_serial_receiver
    import asr_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // serial line
    input  wire logic        rxLine,
    // axi4-lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // interrupt
    output logic             irq
);
    typedef struct packed {
        logic        awHave;
        logic [11:0] awAddr;
        logic        wHave;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        awReady;
        logic        wReady;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arReady;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [6:0]  ctrl;
        logic [15:0] rate;
        logic        full;
        logic        overrun_framing_err_flag;
        logic        par;
        logic [7:0]  data;
        logic        statSeen;
        logic [2:0]  irqStat;
        logic [2:0]  irqMask;
        logic        irq;
    } asr_top_s;

    asr_top_s    s_q, s_d;
    asr_rx_if    fr ();
    logic        rxEn, wake, doWrite, doRead;
    logic        t1Wr, t2Wr, tick;
    logic [15:0] t1Cnt, timer2_counter;
    logic [11:0] wAddr;
    logic [2:0]  evt;

    assign rxEn = s_q.ctrl[`ASR_CTRL_RXEN];
    assign wake = s_q.ctrl[`ASR_CTRL_WAKE];

    asr_rate_gen #(
        .DIV_W (16)
    ) u_rate (
        .clk        (clk),
        .reset      (reset),
        .useTimer2  (s_q.ctrl[`ASR_CTRL_SRC]),
        .t2Slow     (s_q.ctrl[`ASR_CTRL_T2SEL]),
        .rateDiv    (s_q.rate),
        .t1Write    (t1Wr),
        .t2Write    (t2Wr),
        .wrData     (s_q.wData[15:0]),
        .t1Count    (t1Cnt),
        .t2Count    (timer2_counter),
        .sampleTick (tick)
    );

    asr_bit_engine u_engine (
        .clk        (clk),
        .reset      (reset),
        .sampleTick (tick),
        .active     (rxEn && !wake),
        .stop2      (s_q.ctrl[`ASR_CTRL_STOP2]),
        .parEn      (s_q.ctrl[`ASR_CTRL_PAREN]),
        .parOdd     (s_q.ctrl[`ASR_CTRL_PARODD]),
        .rxLine     (rxLine),
        .fr         (fr)
    );

    assign doWrite = s_q.awHave && s_q.wHave && !s_q.bValid;
    assign wAddr   = s_q.awAddr;
    assign t1Wr    = doWrite && (wAddr == `ASR_OFF_TIMER1);
    assign t2Wr    = doWrite && (wAddr == `ASR_OFF_TIMER2);
    assign doRead  = s_axi_arvalid && s_q.arReady;

    always_comb begin
        s_d = s_q;
        evt = 3'h0;
        // write channels taken in either order
        if (s_axi_awvalid && s_q.awReady) begin
            s_d.awHave  = 1'b1;
            s_d.awAddr  = s_axi_awaddr;
            s_d.awReady = 1'b0;
        end
        if (s_axi_wvalid && s_q.wReady) begin
            s_d.wHave  = 1'b1;
            s_d.wData  = s_axi_wdata;
            s_d.wStrb  = s_axi_wstrb;
            s_d.wReady = 1'b0;
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid  = 1'b0;
            s_d.awReady = 1'b1;
            s_d.wReady  = 1'b1;
        end
        if (doWrite) begin
            s_d.awHave = 1'b0;
            s_d.wHave  = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp  = 2'b00;
            if (wAddr == `ASR_OFF_CTRL) begin
                if (s_q.wStrb[0]) begin
                    s_d.ctrl = s_q.wData[6:0];
                    // wake-up only sticks when enable was already set [R5]
                    if (!rxEn) begin
                        s_d.ctrl[`ASR_CTRL_WAKE] = 1'b0;
                    end
                    // a zero clears wake-up; engine runs next cycle [R6]
                end
            end else if (wAddr == `ASR_OFF_RATE) begin
                if (s_q.wStrb[0]) s_d.rate[7:0] = s_q.wData[7:0];
                if (s_q.wStrb[1]) s_d.rate[15:8] = s_q.wData[15:8];
            end else if (wAddr == `ASR_OFF_IRQ_STAT) begin
                if (s_q.wStrb[0]) s_d.irqStat = s_q.irqStat & ~s_q.wData[2:0];
            end else if (wAddr == `ASR_OFF_IRQ_MASK) begin
                if (s_q.wStrb[0]) s_d.irqMask = s_q.wData[2:0];
            end else if (wAddr == `ASR_OFF_TIMER1 ||
                         wAddr == `ASR_OFF_TIMER2 ||
                         wAddr == `ASR_OFF_STATUS ||
                         wAddr == `ASR_OFF_DATA) begin
                s_d.bResp = 2'b00;
            end else begin
                s_d.bResp = 2'b10;
            end
        end
        // read channel
        if (s_q.rValid && s_axi_rready) begin
            s_d.rValid  = 1'b0;
            s_d.arReady = 1'b1;
        end
        if (doRead) begin
            s_d.arReady = 1'b0;
            s_d.rValid  = 1'b1;
            s_d.rResp   = 2'b00;
            s_d.rData   = 32'h0000_0000;
            if (s_axi_araddr == `ASR_OFF_CTRL) begin
                s_d.rData[6:0] = s_q.ctrl;
            end else if (s_axi_araddr == `ASR_OFF_STATUS) begin
                s_d.rData[`ASR_ST_FULL] = s_q.full;
                s_d.rData[`ASR_ST_OVERRUN_FRAMING_ERR_FLAG] = s_q.overrun_framing_err_flag;
                s_d.rData[`ASR_ST_PAR]  = s_q.par;
                s_d.rData[`ASR_ST_BUSY] = fr.busy;
                s_d.statSeen = s_q.full || s_q.overrun_framing_err_flag;
            end else if (s_axi_araddr == `ASR_OFF_DATA) begin
                s_d.rData[7:0] = s_q.data;
                // status read then data read clears the flags [R17]
                if (s_q.statSeen) begin
                    s_d.full     = 1'b0;
                    s_d.overrun_framing_err_flag     = 1'b0;
                    s_d.par      = 1'b0;
                    s_d.statSeen = 1'b0;
                end
            end else if (s_axi_araddr == `ASR_OFF_RATE) begin
                s_d.rData[15:0] = s_q.rate;
            end else if (s_axi_araddr == `ASR_OFF_IRQ_STAT) begin
                s_d.rData[2:0] = s_q.irqStat;
            end else if (s_axi_araddr == `ASR_OFF_IRQ_MASK) begin
                s_d.rData[2:0] = s_q.irqMask;
            end else if (s_axi_araddr == `ASR_OFF_TIMER1) begin
                s_d.rData[15:0] = t1Cnt;
            end else if (s_axi_araddr == `ASR_OFF_TIMER2) begin
                s_d.rData[15:0] = timer2_counter;
            end else begin
                s_d.rResp = 2'b10;
            end
        end
        // frame completion; set wins over a same-cycle read clear
        if (fr.done) begin
            if (s_q.full) begin
                // overrun masks any parity or framing error [R8]
                s_d.full    = 1'b1; // [R7]
                s_d.overrun_framing_err_flag    = 1'b1;
                s_d.par     = 1'b0;
                evt         = 3'h2;
                // held data is kept, new char dropped [R12]
            end else if (fr.parErr || fr.frmErr) begin
                s_d.full = 1'b0; // [R7] [R9]
                s_d.overrun_framing_err_flag = fr.frmErr;
                s_d.par  = fr.parErr;
                evt      = {fr.parErr, fr.frmErr, 1'b0};
                if (fr.parErr && fr.frmErr) begin
                    s_d.data = fr.data; // readable after double error [R10]
                end
            end else begin
                s_d.full = 1'b1; // [R7]
                s_d.overrun_framing_err_flag = 1'b0;
                s_d.par  = 1'b0;
                s_d.data = fr.data; // load only while full is clear [R12]
                evt      = 3'h1;
            end
            s_d.statSeen = 1'b0;
        end
        if (rxEn && wake) begin
            s_d.full = 1'b0; // [R16]
            evt[0]   = 1'b0;
        end
        s_d.irqStat = s_d.irqStat | evt;
        s_d.irq     = |(s_d.irqStat & s_d.irqMask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q         <= '0;
            s_q.awReady <= 1'b1;
            s_q.wReady  <= 1'b1;
            s_q.arReady <= 1'b1;
            s_q.ctrl    <= `ASR_CTRL_RESET;
            s_q.rate    <= `ASR_RATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awReady;
    assign s_axi_wready  = s_q.wReady;
    assign s_axi_bvalid  = s_q.bValid;
    assign s_axi_bresp   = s_q.bResp;
    assign s_axi_arready = s_q.arReady;
    assign s_axi_rvalid  = s_q.rValid;
    assign s_axi_rdata   = s_q.rData;
    assign s_axi_rresp   = s_q.rResp;
    assign irq           = s_q.irq;
endmodule

// ### test/asr_line_tx.sv
// far-end transmitter model: 12-bit frames, lsb first, 16 clocks a bit
// assumes the receiver rate divisor is 0, so one sample tick per clock
`timescale 1ns/100ps
module asr_line_tx (
    // clock
    input  wire logic        clk,
    // frame request
    input  wire logic        go,
    input  wire logic [11:0] frame,
    // serial side
    output logic             line,
    output logic             busy
);
    logic [11:0] sh;
    logic [7:0]  cnt;
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // line returns to idle high between frames, as a pulled-up wire would
    always @(posedge clk) begin
        if (!busy && go) begin
            sh <= frame;
            cnt <= 8'h00;
            busy <= 1'b1;
            line <= frame[0];
        end else if (busy) begin
            cnt <= cnt + 8'h01;
            if (cnt[3:0] == 4'hf)
                line <= (cnt == 8'hbf) ? 1'b1 : sh[cnt[7:4] + 4'h1];
            if (cnt == 8'hbf)
                busy <= 1'b0;
        end
    end
endmodule

// ### test/asr_checker.sv
// checker: axi4-lite timing and status flag relations of the receiver
// assumes it is bound to async_serial_receiver
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // axi4-lite
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // interrupt
    input wire logic        irq
);
    logic [11:0] rdAddr_q;
    always_ff @(posedge clk)
        if (s_axi_arvalid && s_axi_arready)
            rdAddr_q <= s_axi_araddr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    rd_answer_a: assert property (rdTake |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read not held");
    wr_answer_a: assert property (wrBoth |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
    wr_busy_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    bad_addr_a: assert property (rdTake and s_axi_araddr > 12'h01c |=>
        s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    flag_excl_a:
    assert property (s_axi_rvalid && rdAddr_q == `ASR_OFF_STATUS |->
        !(s_axi_rdata[0] && s_axi_rdata[2])) else $error("full with parity");
    irq_reset_a: assert property ($fell(reset) |-> !irq)
        else $error("irq set after reset");
endmodule
bind async_serial_receiver asr_checker chk_u (.clk, .reset, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .irq);

// ### test/async_serial_receiver_bench.sv
// bench: registers over axi4-lite, frames from the line model
// assumes two stop bits, even parity (odd for the last frame) and rate divisor 0
`timescale 1ns/100ps
`include "asr_regs.svh"
module async_serial_receiver_bench;
    logic        clk = 0, reset = 1, go = 0, rxLine, txBusy, irq;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, frame = 12'hfff;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [65:0] rdQ[$], e;
    logic [1:0]  wrQ[$];
    logic [7:0]  d[7];
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    int          seed = 32'haa7154f9;
    always #20 clk = ~clk;
    async_serial_receiver dut_u (.clk, .reset, .rxLine, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    asr_line_tx tx_u (.clk, .go, .frame, .line(rxLine), .busy(txBusy));
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [1:0] r = 2'b00);
        wrQ.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    // mask selects the bits that the expectation covers
    task automatic rd(input logic [11:0] a, input logic [31:0] v,
                      input logic [31:0] m = 32'h7, input logic [1:0] r = 0);
        rdQ.push_back({m, v, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        s_axi_rready <= 1;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    // pf flips parity, sf pulls the first stop bit low
    task automatic send(input logic [7:0] v, input logic pf = 0,
                        input logic sf = 0);
        frame <= {1'b1, !sf, ^v ^ pf, v, 1'b0};
        go <= 1;
        @(posedge clk);
        go <= 0;
        do @(posedge clk); while (txBusy);
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e = rdQ.pop_front();
            cmp({s_axi_rdata & e[65:34], s_axi_rresp}, e[33:0]);
        end
        if (s_axi_bvalid && s_axi_bready)
            cmp({32'h0, s_axi_bresp}, {32'h0, wrQ.pop_front()});
        if (++cyc > 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 0;
        for (int i = 0; i < 7; i++) d[i] = 8'($random(seed));
        rd(`ASR_OFF_RATE, 32'h000c, 32'hffff);
        rd(`ASR_OFF_CTRL, 32'h0, 32'h7f);
        rd(12'h020, 32'h0, 32'hffffffff, 2'b10);
        wr(12'h020, 32'h0, 2'b10);
        wr(`ASR_OFF_RATE, 32'h0);
        wr(`ASR_OFF_IRQ_MASK, 32'h7);
        wr(`ASR_OFF_CTRL, 32'hf);
        rd(`ASR_OFF_CTRL, 32'hd, 32'h7f);
        send(d[0]);
        wr(`ASR_OFF_CTRL, 32'hf);
        rd(`ASR_OFF_CTRL, 32'hf, 32'h7f);
        rd(`ASR_OFF_STATUS, 32'h0);
        wr(`ASR_OFF_CTRL, 32'hd);
        send(d[1]);
        rd(`ASR_OFF_STATUS, 32'h1);
        cmp(34'(irq), 34'h1);
        wr(`ASR_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        cmp(34'(irq), 34'h0);
        wr(`ASR_OFF_IRQ_STAT, 32'h7);
        wr(`ASR_OFF_IRQ_MASK, 32'h7);
        repeat (2) @(posedge clk);
        cmp(34'(irq), 34'h0);
        rd(`ASR_OFF_DATA, 32'(d[1]), 32'hff);
        rd(`ASR_OFF_STATUS, 32'h0);
        send(d[2]);
        send(d[3], 1);
        rd(`ASR_OFF_STATUS, 32'h3);
        rd(`ASR_OFF_DATA, 32'(d[2]), 32'hff);
        send(d[4], 1);
        rd(`ASR_OFF_STATUS, 32'h4);
        send(d[5], 1, 1);
        rd(`ASR_OFF_STATUS, 32'h6);
        rd(`ASR_OFF_DATA, 32'(d[5]), 32'hff);
        send(d[6], 0, 1);
        rd(`ASR_OFF_STATUS, 32'h2);
        rd(`ASR_OFF_DATA, 32'(d[5]), 32'hff);
        wr(`ASR_OFF_CTRL, 32'h1d);
        send(d[0], 1);
        rd(`ASR_OFF_STATUS, 32'h1);
        stop_test();
    end
endmodule
